// ==== rtl/pild_pkg.sv ====
`default_nettype none
package pild_pkg;
  localparam int XLEN = 32;
  localparam int REG_AW = 5;

  // major opcodes
  localparam logic [6:0] OPC_IMM_LOAD = 7'h0b;
  localparam logic [6:0] OPC_CUSTOM_MEM = 7'h2b;

  // funct3 values
  localparam logic [2:0] F3_LB = 3'h0;
  localparam logic [2:0] F3_LBU = 3'h4;
  localparam logic [2:0] F3_LH = 3'h1;
  localparam logic [2:0] F3_LHU = 3'h5;
  localparam logic [2:0] F3_LW = 3'h2;
  localparam logic [2:0] F3_SB = 3'h0;
  localparam logic [2:0] F3_SH = 3'h1;
  localparam logic [2:0] F3_SW = 3'h2;
  localparam logic [2:0] F3_REGREG = 3'h3;

  // funct7 field layout of the register-register forms
  localparam int F7_HI_LSB = 5;
  localparam int F7_STORE_BIT = 4;
  localparam int F7_UNSIGNED_BIT = 3;
  localparam int F7_NOINC_BIT = 2;
  localparam logic [1:0] F7_HI_VALUE = 2'h0;

  // instruction field positions
  localparam int OPC_LSB = 0;
  localparam int RD_LSB = 7;
  localparam int F3_LSB = 12;
  localparam int RS1_LSB = 15;
  localparam int RS2_LSB = 20;
  localparam int IMM_I_LSB = 20;
  localparam int IMM_S_HI_LSB = 25;
  localparam int F7_LSB = 25;

  // access sizes, also the low two bits of funct3 and funct7
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hf;
  localparam logic [4:0] REG_ZERO = 5'h00;
endpackage
`default_nettype wire

// ==== rtl/pild_dec_if.sv ====
`default_nettype none
interface pild_dec_if;
  logic [31:0] instr;
  logic legal;
  logic is_store;
  logic post_inc;
  logic use_imm;
  logic unsigned_ld;
  logic [1:0] size;
  logic [31:0] imm;
  logic [4:0] rs1;
  logic [4:0] off_reg;
  logic [4:0] src_reg;
  logic [4:0] rd;

  modport decoder (
    input instr,
    output legal, is_store, post_inc, use_imm, unsigned_ld, size, imm,
    output rs1, off_reg, src_reg, rd
  );
  modport user (
    output instr,
    input legal, is_store, post_inc, use_imm, unsigned_ld, size, imm,
    input rs1, off_reg, src_reg, rd
  );
endinterface
`default_nettype wire

// ==== rtl/pild_decode.sv ====
`default_nettype none
module pild_decode #(
  parameter bit CUSTOM_EXTENSION_ENABLE = 1'b1
) (
  pild_dec_if.decoder dec
);
  import pild_pkg::*;

  logic [6:0] opc;
  logic [2:0] f3;
  logic [6:0] f7;
  logic [1:0] f7_size;
  logic f7_legal;

  assign opc = dec.instr[OPC_LSB +: 7];
  assign f3 = dec.instr[F3_LSB +: 3];
  assign f7 = dec.instr[F7_LSB +: 7];
  assign f7_size = f7[1:0];
  // stores have no unsigned form; no unsigned word; size 3 unused
  assign f7_legal = (f7[F7_HI_LSB +: 2] == F7_HI_VALUE) && (f7_size != 2'h3)
    && !(f7[F7_STORE_BIT] && f7[F7_UNSIGNED_BIT])
    && !(f7[F7_UNSIGNED_BIT] && (f7_size == SIZE_WORD));

  always_comb begin
    dec.legal = 1'b0;
    dec.is_store = 1'b0;
    dec.post_inc = 1'b1;
    dec.use_imm = 1'b1;
    dec.unsigned_ld = 1'b0;
    dec.size = SIZE_WORD;
    dec.imm = {{20{dec.instr[31]}}, dec.instr[IMM_I_LSB +: 12]};
    dec.rs1 = dec.instr[RS1_LSB +: 5];
    dec.off_reg = dec.instr[RS2_LSB +: 5];
    dec.src_reg = dec.instr[RS2_LSB +: 5];
    dec.rd = dec.instr[RD_LSB +: 5];
    if (opc == OPC_IMM_LOAD) begin
      dec.size = f3[1:0];
      dec.unsigned_ld = f3[2];
      dec.legal = (f3 == F3_LB) || (f3 == F3_LBU) || (f3 == F3_LH) || (f3 == F3_LHU)
        || (f3 == F3_LW);
    end else if (opc == OPC_CUSTOM_MEM) begin
      if (f3 == F3_REGREG) begin
        dec.use_imm = 1'b0;
        dec.is_store = f7[F7_STORE_BIT];
        dec.post_inc = !f7[F7_NOINC_BIT];
        dec.unsigned_ld = f7[F7_UNSIGNED_BIT];
        dec.size = f7_size;
        dec.off_reg = dec.is_store ? dec.instr[RD_LSB +: 5] : dec.instr[RS2_LSB +: 5];
        dec.legal = f7_legal;
      end else begin
        dec.is_store = 1'b1;
        dec.size = f3[1:0];
        dec.imm = {{20{dec.instr[31]}}, dec.instr[IMM_S_HI_LSB +: 7],
          dec.instr[RD_LSB +: 5]};
        dec.legal = (f3 == F3_SB) || (f3 == F3_SH) || (f3 == F3_SW);
      end
    end
    if (!CUSTOM_EXTENSION_ENABLE) begin
      dec.legal = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pild_top.sv ====
`default_nettype none
module pild_top #(
  parameter bit CUSTOM_EXTENSION_ENABLE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [pild_pkg::XLEN-1:0] i_instr,
  output logic o_instr_ready,
  output logic o_illegal,
  output logic o_done,
  output logic [pild_pkg::REG_AW-1:0] o_rf_raddr_base,
  output logic [pild_pkg::REG_AW-1:0] o_rf_raddr_off,
  output logic [pild_pkg::REG_AW-1:0] o_rf_raddr_src,
  input wire logic [pild_pkg::XLEN-1:0] i_rf_rdata_base,
  input wire logic [pild_pkg::XLEN-1:0] i_rf_rdata_off,
  input wire logic [pild_pkg::XLEN-1:0] i_rf_rdata_src,
  output logic o_rf_we_dest,
  output logic [pild_pkg::REG_AW-1:0] o_rf_waddr_dest,
  output logic [pild_pkg::XLEN-1:0] o_rf_wdata_dest,
  output logic o_rf_we_base,
  output logic [pild_pkg::REG_AW-1:0] o_rf_waddr_base,
  output logic [pild_pkg::XLEN-1:0] o_rf_wdata_base,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [pild_pkg::XLEN-1:0] o_mem_addr,
  output logic [3:0] o_mem_be,
  output logic [pild_pkg::XLEN-1:0] o_mem_wdata,
  input wire logic i_mem_gnt,
  input wire logic i_mem_rvalid,
  input wire logic [pild_pkg::XLEN-1:0] i_mem_rdata
);
  import pild_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_REQ,
    ST_RESP,
    ST_WB
  } pild_state_e;

  typedef struct packed {
    pild_state_e st;
    logic ready;
    logic illegal;
    logic done;
    logic is_store;
    logic post_inc;
    logic use_imm;
    logic unsigned_ld;
    logic [1:0] size;
    logic [XLEN-1:0] imm;
    logic [REG_AW-1:0] rd;
    logic [REG_AW-1:0] ra_base;
    logic [REG_AW-1:0] ra_off;
    logic [REG_AW-1:0] ra_src;
    logic [XLEN-1:0] incr;
    logic mem_req;
    logic mem_we;
    logic [XLEN-1:0] mem_addr;
    logic [3:0] mem_be;
    logic [XLEN-1:0] mem_wdata;
    logic we_dest;
    logic [XLEN-1:0] wd_dest;
    logic we_base;
    logic [XLEN-1:0] wd_base;
  } pild_state_s;

  pild_state_s state_reg;
  pild_state_s state_next;

  pild_dec_if dec ();

  assign dec.instr = i_instr;

  pild_decode #(
    .CUSTOM_EXTENSION_ENABLE(CUSTOM_EXTENSION_ENABLE)
  ) u_decode (
    .dec(dec)
  );

  logic take;
  logic [XLEN-1:0] offset_val;
  logic [XLEN-1:0] sum_val;
  logic [XLEN-1:0] access_addr;
  logic [1:0] lane;
  logic [1:0] rlane;
  logic [XLEN-1:0] picked;
  logic fill;
  logic [XLEN-1:0] load_val;
  logic [3:0] be_val;
  logic [XLEN-1:0] wdata_val;
  logic base_wb_post;
  logic base_wb_load;
  logic dest_wb_load;

  // the offset is either the sign-extended immediate or a register value
  assign offset_val = state_reg.use_imm ? state_reg.imm : i_rf_rdata_off;
  assign sum_val = i_rf_rdata_base + offset_val;
  // post-increment uses the untouched base; indexed forms use the sum
  assign access_addr = state_reg.post_inc ? i_rf_rdata_base : sum_val;
  assign lane = access_addr[1:0];

  // an offer is taken only while ready shows, so nothing slips in right after reset
  assign take = state_reg.ready && i_instr_valid;

  // base write-back happens only for post-increment forms and never to x0; a load
  // that names its base as destination keeps the loaded data in that register
  assign base_wb_post = state_reg.post_inc && (state_reg.ra_base != REG_ZERO);
  assign base_wb_load = base_wb_post && (state_reg.ra_base != state_reg.rd);
  assign dest_wb_load = state_reg.rd != REG_ZERO;

  // store lanes: each byte lane takes its strobe; byte and half stores repeat the low source byte or half across the lanes
  for (genvar g = 0; g < 4; g++) begin : g_store_lane
    logic hit;
    logic [7:0] byte_val;
    always_comb begin
      case (state_reg.size)
        SIZE_BYTE: begin
          hit = lane == 2'(g);
          byte_val = i_rf_rdata_src[7:0];
        end
        SIZE_HALF: begin
          hit = lane[1] == 1'(g / 2);
          byte_val = i_rf_rdata_src[8*(g%2) +: 8];
        end
        default: begin
          hit = 1'b1;
          byte_val = i_rf_rdata_src[8*g +: 8];
        end
      endcase
    end
    assign be_val[g] = hit;
    assign wdata_val[8*g +: 8] = byte_val;
  end

  // narrow loads come back on their own lane; result byte g takes lane addr+g
  assign rlane = state_reg.mem_addr[1:0];

  for (genvar g = 0; g < 4; g++) begin : g_load_lane
    logic [1:0] src_lane;
    assign src_lane = rlane + 2'(g);
    assign picked[8*g +: 8] = i_mem_rdata[8*src_lane +: 8];
  end

  // signed forms copy the top bit of the accessed size upwards, unsigned fill zero
  always_comb begin
    fill = 1'b0;
    load_val = picked;
    case (state_reg.size)
      SIZE_BYTE: begin
        fill = !state_reg.unsigned_ld && picked[7];
        load_val = {{24{fill}}, picked[7:0]};
      end
      SIZE_HALF: begin
        fill = !state_reg.unsigned_ld && picked[15];
        load_val = {{16{fill}}, picked[15:0]};
      end
      default: begin
        load_val = picked;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.illegal = 1'b0;
    state_next.done = 1'b0;
    case (state_reg.st)
      ST_IDLE: begin
        // offers while busy are never looked at; illegal ones leave ready high
        state_next.ready = 1'b1;
        if (take) begin
          if (dec.legal) begin
            state_next.st = ST_READ;
            state_next.ready = 1'b0;
            state_next.is_store = dec.is_store;
            state_next.post_inc = dec.post_inc;
            state_next.use_imm = dec.use_imm;
            state_next.unsigned_ld = dec.unsigned_ld;
            state_next.size = dec.size;
            state_next.imm = dec.imm;
            state_next.rd = dec.rd;
            state_next.ra_base = dec.rs1;
            state_next.ra_off = dec.off_reg;
            state_next.ra_src = dec.src_reg;
          end else begin
            // unknown or disabled encodings touch nothing
            state_next.illegal = 1'b1;
          end
        end
      end
      ST_READ: begin
        // register file answers the held read addresses in this cycle
        state_next.st = ST_REQ;
        state_next.incr = sum_val;
        state_next.mem_req = 1'b1;
        state_next.mem_we = state_reg.is_store;
        state_next.mem_addr = access_addr;
        // loads ask for all lanes and pick theirs when the word returns
        state_next.mem_be = state_reg.is_store ? be_val : BE_WORD;
        state_next.mem_wdata = state_reg.is_store ? wdata_val : '0;
      end
      ST_REQ: begin
        // request and its qualifiers stand until the grant edge
        if (i_mem_gnt) begin
          state_next.mem_req = 1'b0;
          state_next.mem_we = 1'b0;
          if (state_reg.is_store) begin
            state_next.st = ST_WB;
            state_next.we_base = base_wb_post;
            state_next.wd_base = state_reg.incr;
          end else begin
            state_next.st = ST_RESP;
          end
        end
      end
      ST_RESP: begin
        // the answer may come any number of cycles after the grant
        if (i_mem_rvalid) begin
          state_next.st = ST_WB;
          state_next.we_dest = dest_wb_load;
          state_next.wd_dest = load_val;
          // same register as base and destination keeps the loaded data
          state_next.we_base = base_wb_load;
          state_next.wd_base = state_reg.incr;
        end
      end
      ST_WB: begin
        // write pulses last one cycle and done follows them
        state_next.st = ST_IDLE;
        state_next.we_dest = 1'b0;
        state_next.we_base = 1'b0;
        state_next.done = 1'b1;
        state_next.ready = 1'b1;
      end
      default: begin
        state_next.st = ST_IDLE;
        state_next.ready = 1'b1;
      end
    endcase
  end

  // a low enable freezes the memory handshake too: the far side must hold its answer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.st <= ST_IDLE;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // every output is a field of the registered state
  assign o_instr_ready = state_reg.ready;
  assign o_illegal = state_reg.illegal;
  assign o_done = state_reg.done;
  assign o_rf_raddr_base = state_reg.ra_base;
  assign o_rf_raddr_off = state_reg.ra_off;
  assign o_rf_raddr_src = state_reg.ra_src;
  assign o_rf_we_dest = state_reg.we_dest;
  assign o_rf_waddr_dest = state_reg.rd;
  assign o_rf_wdata_dest = state_reg.wd_dest;
  assign o_rf_we_base = state_reg.we_base;
  assign o_rf_waddr_base = state_reg.ra_base;
  assign o_rf_wdata_base = state_reg.wd_base;
  assign o_mem_req = state_reg.mem_req;
  assign o_mem_we = state_reg.mem_we;
  assign o_mem_addr = state_reg.mem_addr;
  assign o_mem_be = state_reg.mem_be;
  assign o_mem_wdata = state_reg.mem_wdata;
endmodule
`default_nettype wire

// ==== test/pild_top_properties.sv ====
`default_nettype none
module pild_props #(
  parameter bit CUSTOM_EXTENSION_ENABLE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic i_mem_gnt,
  input wire logic o_instr_ready,
  input wire logic o_illegal,
  input wire logic o_done,
  input wire logic o_rf_we_dest,
  input wire logic [pild_pkg::REG_AW-1:0] o_rf_waddr_dest,
  input wire logic o_rf_we_base,
  input wire logic [pild_pkg::REG_AW-1:0] o_rf_waddr_base,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [pild_pkg::XLEN-1:0] o_mem_addr,
  input wire logic [3:0] o_mem_be
);
  timeunit 1ns;
  timeprecision 1ps;
  import pild_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_req_held: assert property (o_mem_req && !i_mem_gnt && i_ce |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)) else $error("request dropped");
  a_illegal_quiet: assert property (o_illegal |-> o_instr_ready && !o_mem_req
    && !o_rf_we_dest && !o_rf_we_base) else $error("illegal with side effect");
  a_disabled_quiet: assert property (!CUSTOM_EXTENSION_ENABLE |-> !o_mem_req
    && !o_rf_we_dest && !o_rf_we_base) else $error("disabled block acted");
  a_disabled_refuse: assert property (!CUSTOM_EXTENSION_ENABLE && i_ce
    && i_instr_valid && o_instr_ready |=> o_illegal) else $error("no illegal flag");
  a_load_lanes: assert property (o_mem_req && !o_mem_we |-> o_mem_be == BE_WORD)
    else $error("load lanes wrong");
  a_write_apart: assert property (o_rf_we_dest && o_rf_we_base |->
    o_rf_waddr_dest != o_rf_waddr_base) else $error("dest and base collide");
  a_base_nonzero: assert property (o_rf_we_base |-> o_rf_waddr_base != REG_ZERO)
    else $error("base write to zero");
  a_done_follows: assert property (o_rf_we_dest || o_rf_we_base |=>
    o_done && o_instr_ready) else $error("done late");
endmodule
bind pild_top pild_props #(.CUSTOM_EXTENSION_ENABLE(CUSTOM_EXTENSION_ENABLE)) u_props (
  .i_clk, .i_rst, .i_ce, .i_instr_valid, .i_mem_gnt, .o_instr_ready, .o_illegal, .o_done,
  .o_rf_we_dest, .o_rf_waddr_dest, .o_rf_we_base, .o_rf_waddr_base, .o_mem_req, .o_mem_we,
  .o_mem_addr, .o_mem_be);
`default_nettype wire

// ==== test/pild_mem_model.sv ====
`default_nettype none
module pild_mem_model (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [4:0] i_ra_base,
  input wire logic [4:0] i_ra_off,
  input wire logic [4:0] i_ra_src,
  output logic o_gnt,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [31:0] o_rd_base,
  output logic [31:0] o_rd_off,
  output logic [31:0] o_rd_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rf [32];
  logic [31:0] la = 0;
  logic pend = 0;
  assign o_rd_base = rf[i_ra_base];
  assign o_rd_off = rf[i_ra_off];
  assign o_rd_src = rf[i_ra_src];
  // stale data is inverted so a late sample never looks like a hit
  assign o_rdata = o_rvalid ? {la[31:2], 2'h0} * 32'h9e3779b1 : ~({la[31:2], 2'h0} * 32'h9e3779b1);
  initial o_gnt = 0;
  initial o_rvalid = 0;
  always @(posedge i_clk) begin
    if (i_req && o_gnt) begin
      la <= i_addr;
      pend <= !i_we;
    end
    if (o_rvalid) pend <= 1'b0;
  end
  always @(negedge i_clk) begin
    o_gnt <= i_req && ($urandom % 3 != 0);
    o_rvalid <= pend && !o_rvalid && ($urandom % 2 == 1);
  end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pild_pkg::*;
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_instr_valid = 0, ill2;
  logic [31:0] i_instr = 0, i_rf_rdata_base, i_rf_rdata_off, i_rf_rdata_src, i_mem_rdata;
  logic o_instr_ready, o_illegal, o_done, o_rf_we_dest, o_rf_we_base, o_mem_req, o_mem_we;
  logic i_mem_gnt, i_mem_rvalid, c_we;
  logic [4:0] o_rf_raddr_base, o_rf_raddr_off, o_rf_raddr_src, o_rf_waddr_dest, o_rf_waddr_base;
  logic [31:0] o_rf_wdata_dest, o_rf_wdata_base, o_mem_addr, o_mem_wdata, c_a, c_w, c_dd, c_bd;
  logic [3:0] o_mem_be, c_be;
  logic [4:0] c_da, c_ba;
  int err_count = 0, n_compared = 0, nd, nb, nm;
  pild_top DUT (.i_clk, .i_rst, .i_ce, .i_instr_valid, .i_instr, .o_instr_ready, .o_illegal,
    .o_done, .o_rf_raddr_base, .o_rf_raddr_off, .o_rf_raddr_src, .i_rf_rdata_base,
    .i_rf_rdata_off, .i_rf_rdata_src, .o_rf_we_dest, .o_rf_waddr_dest, .o_rf_wdata_dest,
    .o_rf_we_base, .o_rf_waddr_base, .o_rf_wdata_base, .o_mem_req, .o_mem_we, .o_mem_addr,
    .o_mem_be, .o_mem_wdata, .i_mem_gnt, .i_mem_rvalid, .i_mem_rdata);
  pild_top #(.CUSTOM_EXTENSION_ENABLE(1'b0)) DUT_OFF (.i_clk, .i_rst, .i_ce, .i_instr_valid,
    .i_instr, .o_instr_ready(), .o_illegal(ill2), .o_done(), .o_rf_raddr_base(),
    .o_rf_raddr_off(), .o_rf_raddr_src(), .i_rf_rdata_base, .i_rf_rdata_off, .i_rf_rdata_src,
    .o_rf_we_dest(), .o_rf_waddr_dest(), .o_rf_wdata_dest(), .o_rf_we_base(),
    .o_rf_waddr_base(), .o_rf_wdata_base(), .o_mem_req(), .o_mem_we(), .o_mem_addr(),
    .o_mem_be(), .o_mem_wdata(), .i_mem_gnt(1'b0), .i_mem_rvalid(1'b0), .i_mem_rdata);
  pild_mem_model P (.i_clk, .i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_ra_base(o_rf_raddr_base), .i_ra_off(o_rf_raddr_off), .i_ra_src(o_rf_raddr_src),
    .o_gnt(i_mem_gnt), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata),
    .o_rd_base(i_rf_rdata_base), .o_rd_off(i_rf_rdata_off), .o_rd_src(i_rf_rdata_src));
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_mem_req && i_mem_gnt) begin
      nm++;
      {c_we, c_be, c_a, c_w} = {o_mem_we, o_mem_be, o_mem_addr, o_mem_wdata};
    end
    if (o_rf_we_dest) begin
      nd++;
      {c_da, c_dd} = {o_rf_waddr_dest, o_rf_wdata_dest};
    end
    if (o_rf_we_base) begin
      nb++;
      {c_ba, c_bd} = {o_rf_waddr_base, o_rf_wdata_base};
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // forms 0-4 imm loads, 5-14 reg loads, 15-17 imm stores, 18-23 reg stores, 24-26 illegal
  task automatic one(input int k, input bit same);
    logic [4:0] rd, rs1, rs2;
    logic [11:0] imm;
    logic [1:0] sz;
    logic uns, st, ni, ill, imf, eb;
    logic [31:0] ins, base, off, a, w, src, ed;
    int t;
    {rd, rs1, rs2, imm} = 27'($urandom);
    if (same) rd = rs1;
    st = k >= 15 && k < 24;
    ill = k >= 24;
    imf = k < 5 || (k >= 15 && k < 18);
    ni = (k >= 10 && k < 15) || k >= 21;
    sz = st ? 2'((k - 15) % 3) : 2'((k % 5) / 2);
    uns = !st && (k % 5 == 1 || k % 5 == 3);
    if (k < 5) ins = {imm, rs1, uns, sz, rd, OPC_IMM_LOAD};
    else if (k < 15) ins = {3'h0, uns, ni, sz, rs2, rs1, F3_REGREG, rd, OPC_CUSTOM_MEM};
    else if (k < 18) ins = {imm[11:5], rs2, rs1, 1'b0, sz, imm[4:0], OPC_CUSTOM_MEM};
    else if (k < 24) ins = {3'h1, 1'b0, ni, sz, rs2, rs1, F3_REGREG, rd, OPC_CUSTOM_MEM};
    else if (k == 24) ins = {imm, rs1, 3'h3, rd, OPC_IMM_LOAD};
    else if (k == 25) ins = {7'h20, rs2, rs1, F3_REGREG, rd, OPC_CUSTOM_MEM};
    else ins = {imm, rs1, 3'h4, rd, OPC_CUSTOM_MEM};
    for (int i = 1; i < 32; i++) P.rf[i] = $urandom & 32'hffff_fffc;
    if (rs1 != 0 && sz != SIZE_WORD) P.rf[rs1][1:0] = {1'($urandom), sz == SIZE_BYTE && 1'($urandom)};
    base = P.rf[rs1];
    src = P.rf[rs2];
    off = imf ? {{20{imm[11]}}, imm} : P.rf[st ? rd : rs2];
    a = ni ? base + off : base;
    w = ({a[31:2], 2'h0} * 32'h9e3779b1) >> (8 * a[1:0]);
    ed = sz == SIZE_WORD ? w : sz == SIZE_HALF ? {{16{w[15] & !uns}}, w[15:0]}
      : {{24{w[7] & !uns}}, w[7:0]};
    eb = !ill && !ni && rs1 != 0 && (st || rs1 != rd);
    {nm, nd, nb, t} = 0;
    // let an edge pass so valid is never lowered and raised in one time step
    @(negedge i_clk);
    while (o_instr_ready !== 1'b1 && t < 50) begin
      @(negedge i_clk);
      t++;
    end
    i_instr = ins;
    i_instr_valid = 1;
    @(negedge i_clk);
    i_instr_valid = 0;
    chk(ill2, 1);
    while (o_done !== 1'b1 && o_illegal !== 1'b1 && t < 60) begin
      @(negedge i_clk);
      t++;
    end
    if (t >= 60) err_count++;
    chk(o_illegal, ill);
    chk(nm, !ill);
    chk(nd, !ill && !st && rd != 0);
    chk(nb, eb);
    if (!ill) begin
      chk(c_a, a);
      chk(c_we, st);
      chk(c_be, !st ? BE_WORD : sz == SIZE_BYTE ? BE_BYTE << a[1:0]
        : sz == SIZE_HALF ? BE_HALF << a[1:0] : BE_WORD);
      if (st) chk(c_w, sz == SIZE_BYTE ? {4{src[7:0]}} : sz == SIZE_HALF ? {2{src[15:0]}} : src);
      if (nd == 1) chk({c_da, c_dd[26:0]}, {rd, ed[26:0]});
      if (nd == 1) chk(c_dd, ed);
      if (nb == 1) chk(c_bd, base + off);
      if (nb == 1) chk(c_ba, rs1);
    end
  endtask
  initial begin
    void'($urandom(16));
    P.rf[0] = 0;
    repeat (5) @(negedge i_clk);
    i_rst = 0;
    for (int k = 0; k < 54; k++) one(k % 27, k >= 27);
    repeat (400) one($urandom % 27, 0);
    results;
  end
  initial begin
    #(50 * 20000);
    err_count++;
    results;
  end
endmodule
`default_nettype wire
